// file: verilog/frh_pkg.sv
package frh_pkg;
	localparam int SRC_W = 16;
	localparam int SEL_W = 4;
	localparam int TBL_N = 20;
	localparam int TBL_AW = 5;
	localparam int BUF_N = 64;
	localparam int BUF_AW = 6;
	localparam int RESP_W = 3;
	// response codes
	localparam logic [2:0] RESP_NONE = 3'h0;
	localparam logic [2:0] RESP_RAMP = 3'h1;
	localparam logic [2:0] RESP_COAST = 3'h2;
	localparam logic [2:0] RESP_FAST = 3'h3;
	localparam logic [2:0] RESP_ZERO = 3'h5;
	localparam logic [2:0] RESP_BRAKE = 3'h6;
	localparam logic [2:0] ARM_SHORT_OK = 3'h4;
	// timing
	localparam int CLK_NS = 100;
	localparam int MS_NS = 1000000;
	localparam int CYC_PER_MS = MS_NS / CLK_NS;
	localparam int MS_PER_DAY = 86400000;
	// register byte offsets
	localparam logic [7:0] OFS_ACK1_SEL = 8'h00;
	localparam logic [7:0] OFS_ACK23_SEL = 8'h04;
	localparam logic [7:0] OFS_EXT_SEL = 8'h08;
	localparam logic [7:0] OFS_CONFIG = 8'h0c;
	localparam logic [7:0] OFS_TBL_IDX = 8'h10;
	localparam logic [7:0] OFS_TBL_NUM = 8'h14;
	localparam logic [7:0] OFS_TBL_RESP = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1c;
	localparam logic [7:0] OFS_BUF_IDX = 8'h20;
	localparam logic [7:0] OFS_BUF_MS = 8'h24;
	localparam logic [7:0] OFS_BUF_DAY = 8'h28;
	localparam logic [7:0] OFS_RT_MS = 8'h2c;
	localparam logic [7:0] OFS_RT_DAY = 8'h30;
	// field positions
	localparam int ACK2_POS = 0;
	localparam int ACK3_POS = 4;
	localparam int EXT1_POS = 0;
	localparam int EXT2_POS = 4;
	localparam int EXT3_POS = 8;
	localparam int EXT3EN_POS = 12;
	localparam int EXT3CD_POS = 16;
	localparam int CFG_TPROT_POS = 0;
	localparam int CFG_XPROT_POS = 1;
	localparam int CFG_ARM_POS = 4;
	localparam int ST_REJECT_POS = 7;
	// reset values
	localparam logic [3:0] SEL_RST = 4'h0;
	localparam logic [2:0] ARM_RST = 3'h0;
	localparam logic [15:0] NUM_RST = 16'h0000;
	typedef enum logic [1:0] {
		FRH_IDLE = 2'b00,
		FRH_STOP = 2'b01,
		FRH_INHIBIT = 2'b11
	} frh_state_e;
endpackage

// file: verilog/frh_runtime.sv
module frh_runtime
	import frh_pkg::*;
#(
	parameter int CYCLES_PER_MS = CYC_PER_MS,
	parameter int MS_DAY = MS_PER_DAY
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// runtime
	output logic [31:0] ms_reg,
	output logic [31:0] day_reg
);
	logic [31:0] tick_reg;
	logic tick;

	assign tick = (tick_reg == 32'(CYCLES_PER_MS - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_reg <= 32'h0;
		end else if (tick) begin
			tick_reg <= 32'h0;
		end else begin
			tick_reg <= tick_reg + 32'h1;
		end
	end

	// reaching a full day clears the millisecond count and bumps the day
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_reg <= 32'h0;
			day_reg <= 32'h0;
		end else if (tick) begin
			if (ms_reg + 32'h1 == 32'(MS_DAY)) begin
				ms_reg <= 32'h0;
				day_reg <= day_reg + 32'h1;
			end else begin
				ms_reg <= ms_reg + 32'h1;
			end
		end
	end

	property p_day_roll;
		@(posedge pclk) disable iff (!presetn)
		tick && (ms_reg == 32'(MS_DAY - 1)) |=> (ms_reg == 32'h0) && (day_reg == $past(day_reg) + 32'h1);
	endproperty
	a_day_roll: assert property (p_day_roll) else $error("day rollover wrong");
endmodule

// file: verilog/frh_fault_handler.sv
// Functional notes
// - twenty entry table pairing fault numbers with chosen responses by index
// - response codes 0 none, 1 ramp, 2 coast, 3 fast, 5 zero, 6 brake
// - table may change anytime; active fault keeps its latched response
// - override ignored for zero number, non-fault type or unpermitted response
// - override used only where the fault's permit mask allows that code
// - code 1 ramps down normally, then pulse inhibit on ramp done
// - code 2 gives pulse inhibit at once, no ramp
// - code 3 ramps down on fast ramp, then pulse inhibit
// - code 5 forces speed setpoint to zero
// - code 6 accepted only while armature short config equals 4
// - rising edge on any of three selected sources acknowledges the fault
// - first acknowledge selection is write locked while either protection is set
// - falling edge on a selected source raises its external fault
// - external fault 3 is not-source and enable and not-condition
// - sixty-four entry buffer records runtime milliseconds when fault removed
// - a matching day entry is stored at the same buffer index
// - buffer view refreshed in background with a busy status bit
// - runtime milliseconds wrap at a full day and increment days
module frh_fault_handler
	import frh_pkg::*;
#(
	parameter int CYCLES_PER_MS = CYC_PER_MS,
	parameter int MS_DAY = MS_PER_DAY,
	parameter logic [15:0] EXT1_NUM = 16'h1eb4,
	parameter logic [15:0] EXT2_NUM = 16'h1eb5,
	parameter logic [15:0] EXT3_NUM = 16'h1eb6,
	parameter logic [2:0] EXT_DEF_RESP = 3'h2,
	parameter logic [7:0] EXT_ALLOWED = 8'h6f
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// binary sources from pins
	input wire logic [SRC_W-1:0] bin_src,
	// internal fault request
	input wire logic flt_req,
	input wire logic [15:0] flt_num,
	input wire logic [2:0] flt_default,
	input wire logic [7:0] flt_allowed,
	input wire logic flt_is_fault,
	// drive feedback
	input wire logic ramp_done,
	input wire logic fast_ramp_done,
	// stop actions
	output logic ramp_stop,
	output logic coast_pulse_inhibit,
	output logic fast_ramp_stop,
	output logic zero_speed_hold,
	output logic dc_brake,
	output logic pulse_inhibit
);
	logic [SEL_W-1:0] ack_source_first, ack_source_second, ack_source_third;
	logic [SEL_W-1:0] ext_fault_one_source, ext_fault_two_source, ext_fault_three_source;
	logic [SEL_W-1:0] ext_fault_three_enable, ext_fault_three_condition;
	logic telegram_protect_setting, extended_telegram_setting, reject_reg;
	logic [2:0] armature_short_config;
	logic [TBL_AW-1:0] tbl_idx_reg;
	logic [15:0] override_fault_number [TBL_N];
	logic [2:0] override_response_code [TBL_N];
	logic [BUF_AW-1:0] buf_idx_reg, wr_ptr_reg, ref_idx_reg;
	logic [31:0] fault_removed_ms [BUF_N];
	logic [31:0] fault_removed_days [BUF_N];
	logic [31:0] view_ms [BUF_N];
	logic [31:0] view_days [BUF_N];
	logic buffer_refresh_status;
	logic [31:0] rt_ms, rt_day;
	logic [SRC_W-1:0] src_meta_reg, src_sync_reg, src_prev_reg;
	logic ext3_term, ext3_prev_reg, ack_rise, ext1_fall, ext2_fall, ext3_fall;
	frh_state_e state_reg, state_next;
	logic [2:0] resp_reg, resp_next;
	logic [15:0] num_reg;
	logic raise, record, cand_valid, cand_isf, hit;
	logic [15:0] cand_num;
	logic [2:0] cand_def, hit_resp;
	logic [7:0] cand_allowed;
	logic setup, wr_en, rd_map;
	logic [31:0] rd_val;

	frh_runtime #(
		.CYCLES_PER_MS(CYCLES_PER_MS),
		.MS_DAY(MS_DAY)
	) u_runtime (
		.pclk(pclk),
		.presetn(presetn),
		.ms_reg(rt_ms),
		.day_reg(rt_day)
	);

	// two stage synchroniser, then a previous-sample register for edges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_meta_reg <= '0;
			src_sync_reg <= '0;
			src_prev_reg <= '0;
			ext3_prev_reg <= 1'b0;
		end else begin
			src_meta_reg <= bin_src;
			src_sync_reg <= src_meta_reg;
			src_prev_reg <= src_sync_reg;
			ext3_prev_reg <= ext3_term;
		end
	end

	assign ext3_term = ~src_sync_reg[ext_fault_three_source]
		& src_sync_reg[ext_fault_three_enable]
		& ~src_sync_reg[ext_fault_three_condition];
	assign ack_rise = (src_sync_reg[ack_source_first] & ~src_prev_reg[ack_source_first])
		| (src_sync_reg[ack_source_second] & ~src_prev_reg[ack_source_second])
		| (src_sync_reg[ack_source_third] & ~src_prev_reg[ack_source_third]);
	assign ext1_fall = ~src_sync_reg[ext_fault_one_source]
		& src_prev_reg[ext_fault_one_source];
	assign ext2_fall = ~src_sync_reg[ext_fault_two_source]
		& src_prev_reg[ext_fault_two_source];
	assign ext3_fall = ext3_term & ~ext3_prev_reg;

	// one fault slot; external inputs take priority over the internal request
	always_comb begin
		cand_valid = 1'b1;
		cand_isf = 1'b1;
		cand_def = EXT_DEF_RESP;
		cand_allowed = EXT_ALLOWED;
		cand_num = EXT1_NUM;
		if (ext1_fall) begin
			cand_num = EXT1_NUM;
		end else if (ext2_fall) begin
			cand_num = EXT2_NUM;
		end else if (ext3_fall) begin
			cand_num = EXT3_NUM;
		end else begin
			cand_valid = flt_req;
			cand_isf = flt_is_fault;
			cand_def = flt_default;
			cand_allowed = flt_allowed;
			cand_num = flt_num;
		end
	end

	// lowest matching index wins
	always_comb begin
		hit = 1'b0;
		hit_resp = RESP_NONE;
		for (int i = TBL_N - 1; i >= 0; i--) begin
			if (override_fault_number[i] != NUM_RST && override_fault_number[i] == cand_num) begin
				hit = 1'b1;
				hit_resp = override_response_code[i];
			end
		end
	end

	assign raise = (state_reg == FRH_IDLE) && cand_valid;
	assign record = (state_reg != FRH_IDLE) && ack_rise;

	always_comb begin
		state_next = state_reg;
		resp_next = resp_reg;
		if (raise) begin
			resp_next = cand_def;
			if (hit && cand_isf && cand_allowed[hit_resp]
				&& (hit_resp != RESP_BRAKE || armature_short_config == ARM_SHORT_OK)) begin
				resp_next = hit_resp;
			end
			state_next = (resp_next == RESP_COAST) ? FRH_INHIBIT : FRH_STOP;
		end else if (record) begin
			state_next = FRH_IDLE;
		end else if (state_reg == FRH_STOP) begin
			if ((resp_reg == RESP_RAMP && ramp_done)
				|| (resp_reg == RESP_FAST && fast_ramp_done)) begin
				state_next = FRH_INHIBIT;
			end
		end
	end

	// response latched at raise, so table edits apply to the next occurrence
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= FRH_IDLE;
			resp_reg <= RESP_NONE;
			num_reg <= NUM_RST;
		end else begin
			state_reg <= state_next;
			resp_reg <= resp_next;
			if (raise) begin
				num_reg <= cand_num;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ramp_stop <= 1'b0;
			coast_pulse_inhibit <= 1'b0;
			fast_ramp_stop <= 1'b0;
			zero_speed_hold <= 1'b0;
			dc_brake <= 1'b0;
			pulse_inhibit <= 1'b0;
		end else begin
			ramp_stop <= (state_next == FRH_STOP) && (resp_next == RESP_RAMP);
			coast_pulse_inhibit <= (state_next != FRH_IDLE) && (resp_next == RESP_COAST);
			fast_ramp_stop <= (state_next == FRH_STOP) && (resp_next == RESP_FAST);
			zero_speed_hold <= (state_next != FRH_IDLE) && (resp_next == RESP_ZERO);
			dc_brake <= (state_next != FRH_IDLE) && (resp_next == RESP_BRAKE);
			pulse_inhibit <= (state_next == FRH_INHIBIT);
		end
	end

	// removal record and background copy into the software view
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr_reg <= '0;
			ref_idx_reg <= '0;
			buffer_refresh_status <= 1'b0;
			for (int i = 0; i < BUF_N; i++) begin
				fault_removed_ms[i] <= 32'h0;
				fault_removed_days[i] <= 32'h0;
				view_ms[i] <= 32'h0;
				view_days[i] <= 32'h0;
			end
		end else begin
			if (record) begin
				fault_removed_ms[wr_ptr_reg] <= rt_ms;
				fault_removed_days[wr_ptr_reg] <= rt_day;
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
				ref_idx_reg <= '0;
				buffer_refresh_status <= 1'b1;
			end else if (buffer_refresh_status) begin
				view_ms[ref_idx_reg] <= fault_removed_ms[ref_idx_reg];
				view_days[ref_idx_reg] <= fault_removed_days[ref_idx_reg];
				ref_idx_reg <= ref_idx_reg + 1'b1;
				buffer_refresh_status <= (ref_idx_reg != BUF_AW'(BUF_N - 1));
			end
		end
	end

	// apb: decode in setup, answer in the first access cycle
	assign setup = psel && !penable;
	assign wr_en = psel && penable && pwrite;
	assign pready = psel && penable;

	always_comb begin
		rd_map = 1'b1;
		rd_val = 32'h0;
		unique case (paddr)
			OFS_ACK1_SEL: rd_val = 32'(ack_source_first);
			OFS_ACK23_SEL: rd_val = 32'({ack_source_third, ack_source_second});
			OFS_EXT_SEL: rd_val = 32'({ext_fault_three_condition, ext_fault_three_enable,
				ext_fault_three_source, ext_fault_two_source, ext_fault_one_source});
			OFS_CONFIG: rd_val = 32'({armature_short_config, 2'b00,
				extended_telegram_setting, telegram_protect_setting});
			OFS_TBL_IDX: rd_val = 32'(tbl_idx_reg);
			OFS_TBL_NUM: rd_val = (tbl_idx_reg < TBL_AW'(TBL_N))
				? 32'(override_fault_number[tbl_idx_reg]) : 32'h0;
			OFS_TBL_RESP: rd_val = (tbl_idx_reg < TBL_AW'(TBL_N))
				? 32'(override_response_code[tbl_idx_reg]) : 32'h0;
			OFS_STATUS: rd_val = {num_reg, 8'h00, reject_reg, buffer_refresh_status,
				state_reg, resp_reg, state_reg != FRH_IDLE};
			OFS_BUF_IDX: rd_val = 32'({wr_ptr_reg, 2'b00, buf_idx_reg});
			OFS_BUF_MS: rd_val = view_ms[buf_idx_reg];
			OFS_BUF_DAY: rd_val = view_days[buf_idx_reg];
			OFS_RT_MS: rd_val = rt_ms;
			OFS_RT_DAY: rd_val = rt_day;
			default: rd_map = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata <= pwrite ? 32'h0 : rd_val;
			pslverr <= !rd_map;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_source_first <= SEL_RST;
			ack_source_second <= SEL_RST;
			ack_source_third <= SEL_RST;
			ext_fault_one_source <= SEL_RST;
			ext_fault_two_source <= SEL_RST;
			ext_fault_three_source <= SEL_RST;
			ext_fault_three_enable <= SEL_RST;
			ext_fault_three_condition <= SEL_RST;
			telegram_protect_setting <= 1'b0;
			extended_telegram_setting <= 1'b0;
			armature_short_config <= ARM_RST;
			tbl_idx_reg <= '0;
			buf_idx_reg <= '0;
		end else if (wr_en) begin
			if (paddr == OFS_ACK1_SEL && !telegram_protect_setting
				&& !extended_telegram_setting) begin
				ack_source_first <= pwdata[SEL_W-1:0];
			end
			if (paddr == OFS_ACK23_SEL) begin
				ack_source_second <= pwdata[ACK2_POS+:SEL_W];
				ack_source_third <= pwdata[ACK3_POS+:SEL_W];
			end
			if (paddr == OFS_EXT_SEL) begin
				ext_fault_one_source <= pwdata[EXT1_POS+:SEL_W];
				ext_fault_two_source <= pwdata[EXT2_POS+:SEL_W];
				ext_fault_three_source <= pwdata[EXT3_POS+:SEL_W];
				ext_fault_three_enable <= pwdata[EXT3EN_POS+:SEL_W];
				ext_fault_three_condition <= pwdata[EXT3CD_POS+:SEL_W];
			end
			if (paddr == OFS_CONFIG) begin
				telegram_protect_setting <= pwdata[CFG_TPROT_POS];
				extended_telegram_setting <= pwdata[CFG_XPROT_POS];
				armature_short_config <= pwdata[CFG_ARM_POS+:3];
			end
			if (paddr == OFS_TBL_IDX) begin
				tbl_idx_reg <= pwdata[TBL_AW-1:0];
			end
			if (paddr == OFS_BUF_IDX) begin
				buf_idx_reg <= pwdata[BUF_AW-1:0];
			end
		end
	end

	// table writes; a bad response code leaves the entry and flags a reject
	logic resp_bad;
	assign resp_bad = (pwdata[2:0] == 3'h4) || (pwdata[2:0] == 3'h7)
		|| (pwdata[31:3] != 29'h0)
		|| (pwdata[2:0] == RESP_BRAKE && armature_short_config != ARM_SHORT_OK);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reject_reg <= 1'b0;
			for (int i = 0; i < TBL_N; i++) begin
				override_fault_number[i] <= NUM_RST;
				override_response_code[i] <= RESP_NONE;
			end
		end else begin
			if (wr_en && tbl_idx_reg < TBL_AW'(TBL_N)) begin
				if (paddr == OFS_TBL_NUM) begin
					override_fault_number[tbl_idx_reg] <= pwdata[15:0];
				end
				if (paddr == OFS_TBL_RESP && !resp_bad) begin
					override_response_code[tbl_idx_reg] <= pwdata[2:0];
				end
			end
			if (wr_en && paddr == OFS_TBL_RESP && resp_bad) begin
				reject_reg <= 1'b1;
			end else if (wr_en && paddr == OFS_STATUS && pwdata[ST_REJECT_POS]) begin
				reject_reg <= 1'b0;
			end
		end
	end

	sequence s_raise_coast;
		raise && resp_next == RESP_COAST;
	endsequence
	sequence s_ramp_end;
		state_reg == FRH_STOP && resp_reg == RESP_RAMP && ramp_done && !ack_rise;
	endsequence
	sequence s_fast_end;
		state_reg == FRH_STOP && resp_reg == RESP_FAST && fast_ramp_done && !ack_rise;
	endsequence

	property p_coast_now;
		@(posedge pclk) disable iff (!presetn)
		s_raise_coast |=> pulse_inhibit && coast_pulse_inhibit && !ramp_stop;
	endproperty
	a_coast_now: assert property (p_coast_now) else $error("coast not immediate");

	property p_ramp_end;
		@(posedge pclk) disable iff (!presetn)
		s_ramp_end |=> pulse_inhibit && !ramp_stop && state_reg == FRH_INHIBIT;
	endproperty
	a_ramp_end: assert property (p_ramp_end) else $error("ramp stop end wrong");

	property p_fast_end;
		@(posedge pclk) disable iff (!presetn)
		s_fast_end |=> pulse_inhibit && !fast_ramp_stop;
	endproperty
	a_fast_end: assert property (p_fast_end) else $error("fast stop end wrong");

	property p_zero_hold;
		@(posedge pclk) disable iff (!presetn)
		state_reg != FRH_IDLE && resp_reg == RESP_ZERO |-> zero_speed_hold && !pulse_inhibit;
	endproperty
	a_zero_hold: assert property (p_zero_hold) else $error("zero hold missing");

	property p_brake_lock;
		@(posedge pclk) disable iff (!presetn)
		wr_en && paddr == OFS_TBL_RESP && pwdata[2:0] == RESP_BRAKE
			&& armature_short_config != ARM_SHORT_OK && tbl_idx_reg < TBL_AW'(TBL_N)
			|=> reject_reg
			&& override_response_code[tbl_idx_reg] == $past(override_response_code[tbl_idx_reg]);
	endproperty
	a_brake_lock: assert property (p_brake_lock) else $error("brake code accepted");

	property p_ack_record;
		@(posedge pclk) disable iff (!presetn)
		record |=> state_reg == FRH_IDLE && wr_ptr_reg == $past(wr_ptr_reg) + 1'b1
			&& fault_removed_ms[$past(wr_ptr_reg)] == $past(rt_ms);
	endproperty
	a_ack_record: assert property (p_ack_record) else $error("ack not recorded");

	property p_protect;
		@(posedge pclk) disable iff (!presetn)
		wr_en && paddr == OFS_ACK1_SEL
			&& (telegram_protect_setting || extended_telegram_setting) |=> $stable(ack_source_first);
	endproperty
	a_protect: assert property (p_protect) else $error("protected write taken");

	property p_ext1;
		@(posedge pclk) disable iff (!presetn)
		state_reg == FRH_IDLE && ext1_fall |=> state_reg != FRH_IDLE && num_reg == EXT1_NUM;
	endproperty
	a_ext1: assert property (p_ext1) else $error("external fault 1 lost");

	property p_refresh;
		@(posedge pclk) disable iff (!presetn)
		record ##1 !record [*8] |-> buffer_refresh_status;
	endproperty
	a_refresh: assert property (p_refresh) else $error("refresh busy dropped");

	property p_keep_resp;
		@(posedge pclk) disable iff (!presetn)
		state_reg != FRH_IDLE && !record |=> $stable(resp_reg) && $stable(num_reg);
	endproperty
	a_keep_resp: assert property (p_keep_resp) else $error("active response changed");
endmodule

// file: tb/frh_drive_model.sv
module frh_drive_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// stop requests and pace
	input wire logic ramp_stop,
	input wire logic fast_ramp_stop,
	input wire logic slow,
	// ramp feedback
	output logic ramp_done,
	output logic fast_ramp_done
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] cnt_reg;
	logic reached;
	// the motor needs time to slow down; done is never reported early
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cnt_reg <= 5'h00;
		else if (ramp_stop || fast_ramp_stop)
			cnt_reg <= (cnt_reg == 5'h1f) ? cnt_reg : cnt_reg + 5'h01;
		else
			cnt_reg <= 5'h00;
	end
	assign reached = cnt_reg >= (slow ? 5'h10 : 5'h02);
	assign ramp_done = ramp_stop && reached;
	assign fast_ramp_done = fast_ramp_stop && reached;
endmodule

// file: tb/test_fault_response_handler.sv
module test_fault_response_handler
	import frh_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er, ramp_done, fast_ramp_done;
	logic slow = 1'b0;
	logic [15:0] bin_src = 16'h003c;
	logic [15:0] flt_num = 16'h0000;
	logic flt_req = 1'b0;
	logic flt_is_fault = 1'b1;
	logic [2:0] flt_default = 3'h0;
	logic [7:0] flt_allowed = 8'hff;
	logic ramp_stop, coast_pulse_inhibit, fast_ramp_stop, zero_speed_hold, dc_brake;
	logic pulse_inhibit;
	logic [5:0] outs;
	int err_total = 0;
	int checked = 0;
	assign outs = {ramp_stop, coast_pulse_inhibit, fast_ramp_stop, zero_speed_hold,
		dc_brake, pulse_inhibit};
	always #50 pclk = ~pclk;
	frh_fault_handler #(.CYCLES_PER_MS(4), .MS_DAY(10)) uut (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .bin_src, .flt_req,
		.flt_num, .flt_default, .flt_allowed, .flt_is_fault, .ramp_done, .fast_ramp_done,
		.ramp_stop, .coast_pulse_inhibit, .fast_ramp_stop, .zero_speed_hold, .dc_brake,
		.pulse_inhibit);
	frh_drive_model drv (.pclk, .presetn, .ramp_stop, .fast_ramp_stop, .slow, .ramp_done,
		.fast_ramp_done);
	task automatic final_report;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// the slave sets the pace; only the watchdog ends a stuck transfer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd & m, e);
	endtask
	task automatic tbl(input logic [4:0] i, input logic [15:0] n, input logic [2:0] c);
		wr(OFS_TBL_IDX, {27'h0, i});
		wr(OFS_TBL_NUM, {16'h0, n});
		wr(OFS_TBL_RESP, {29'h0, c});
	endtask
	task automatic wait_out(input logic [5:0] m);
		int n;
		n = 0;
		while ((outs & m) == 6'h00 && n < 40) begin
			@(posedge pclk);
			n++;
		end
	endtask
	task automatic raise(input logic [15:0] num, input logic [2:0] def, input logic [7:0] al,
		input logic f);
		flt_num <= num;
		flt_default <= def;
		flt_allowed <= al;
		flt_is_fault <= f;
		flt_req <= 1'b1;
		@(posedge pclk);
		flt_req <= 1'b0;
		wait_out(6'h3f);
	endtask
	task automatic ack(input int b);
		int n;
		n = 0;
		bin_src[b] <= 1'b1;
		@(posedge pclk);
		while (outs !== 6'h00 && n < 40) begin
			@(posedge pclk);
			n++;
		end
		chk({26'h0, outs}, 32'h0);
		bin_src[b] <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic t_regs;
		apb(1'b0, 8'h34, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		rdc(OFS_CONFIG, 32'hffffffff, 32'h0);
		wr(OFS_ACK1_SEL, 32'h1);
		wr(OFS_ACK23_SEL, 32'h87);
		wr(OFS_EXT_SEL, 32'h65432);
		for (int p = 0; p < 2; p++) begin
			wr(OFS_CONFIG, 32'h1 << p);
			wr(OFS_ACK1_SEL, 32'h9);
			rdc(OFS_ACK1_SEL, 32'hf, 32'h1);
		end
		wr(OFS_CONFIG, 32'h0);
		$display("test regs done");
	endtask
	task automatic t_table;
		logic [2:0] code [5] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
		logic [5:0] first [5] = '{6'h20, 6'h11, 6'h08, 6'h04, 6'h02};
		tbl(5'h03, 16'h0103, 3'h6);
		rdc(OFS_STATUS, 32'h80, 32'h80);
		rdc(OFS_TBL_RESP, 32'h7, 32'h0);
		wr(OFS_STATUS, 32'h80);
		tbl(5'h03, 16'h0103, 3'h4);
		rdc(OFS_STATUS, 32'h80, 32'h80);
		wr(OFS_STATUS, 32'h80);
		wr(OFS_CONFIG, 32'h40);
		for (int k = 0; k < 5; k++) begin
			slow <= (k == 0);
			tbl(5'(k), 16'h0100 + 16'(k), code[k]);
			raise(16'h0100 + 16'(k), 3'h0, 8'hff, 1'b1);
			chk({26'h0, outs}, {26'h0, first[k]});
			if (k == 0 || k == 2) begin
				wait_out(6'h01);
				chk({31'h0, pulse_inhibit}, 32'h1);
			end
			ack(1);
		end
		$display("test table done");
	endtask
	task automatic t_refuse;
		raise(16'h0100, 3'h2, 8'hff, 1'b0);
		chk({26'h0, outs}, 32'h11);
		ack(1);
		raise(16'h0100, 3'h2, 8'h04, 1'b1);
		chk({26'h0, outs}, 32'h11);
		ack(1);
		tbl(5'h05, 16'h0000, 3'h5);
		raise(16'h0000, 3'h2, 8'hff, 1'b1);
		chk({26'h0, outs}, 32'h11);
		ack(1);
		$display("test refuse done");
	endtask
	task automatic t_live;
		raise(16'h0103, 3'h0, 8'hff, 1'b1);
		tbl(5'h03, 16'h0103, 3'h2);
		chk({26'h0, outs}, 32'h04);
		ack(1);
		raise(16'h0103, 3'h0, 8'hff, 1'b1);
		chk({26'h0, outs}, 32'h11);
		ack(1);
		$display("test live edit done");
	endtask
	task automatic t_ext;
		int src [3] = '{2, 3, 4};
		int ab [3] = '{7, 8, 1};
		for (int k = 0; k < 3; k++) begin
			bin_src[src[k]] <= 1'b0;
			@(posedge pclk);
			wait_out(6'h3f);
			chk({26'h0, outs}, 32'h11);
			rdc(OFS_STATUS, 32'hffff0000, {16'h1eb4 + 16'(k), 16'h0});
			ack(ab[k]);
			bin_src[src[k]] <= 1'b1;
			@(posedge pclk);
		end
		// condition high must block fault 3 even on a falling source
		bin_src[6] <= 1'b1;
		@(posedge pclk);
		bin_src[4] <= 1'b0;
		wait_out(6'h3f);
		chk({26'h0, outs}, 32'h0);
		// enable low must block it as well
		bin_src[6:4] <= 3'b001;
		@(posedge pclk);
		bin_src[4] <= 1'b0;
		wait_out(6'h3f);
		chk({26'h0, outs}, 32'h0);
		bin_src[6:4] <= 3'b011;
		@(posedge pclk);
		$display("test external done");
	endtask
	task automatic t_buf;
		logic [31:0] pre, ptr, ms;
		int n;
		apb(1'b0, OFS_BUF_IDX, 32'h0);
		ptr = (rd >> 8) & 32'h3f;
		apb(1'b0, OFS_RT_DAY, 32'h0);
		pre = rd * 10;
		apb(1'b0, OFS_RT_MS, 32'h0);
		pre = pre + rd;
		raise(16'h0101, 3'h0, 8'hff, 1'b1);
		ack(1);
		rdc(OFS_STATUS, 32'h40, 32'h40);
		n = 0;
		do begin
			apb(1'b0, OFS_STATUS, 32'h0);
			n++;
		end while ((rd & 32'h40) != 32'h0 && n < 40);
		chk(rd & 32'h40, 32'h0);
		rdc(OFS_BUF_IDX, 32'h3f00, ((ptr + 1) & 32'h3f) << 8);
		wr(OFS_BUF_IDX, ptr);
		apb(1'b0, OFS_BUF_MS, 32'h0);
		ms = rd;
		chk({31'h0, ms < 32'd10}, 32'h1);
		apb(1'b0, OFS_BUF_DAY, 32'h0);
		ms = rd * 10 + ms - pre;
		chk({31'h0, ms <= 32'd14}, 32'h1);
		apb(1'b0, OFS_RT_DAY, 32'h0);
		pre = rd;
		repeat (200) @(posedge pclk);
		apb(1'b0, OFS_RT_DAY, 32'h0);
		chk({31'h0, (rd - pre - 32'd4) <= 32'd2}, 32'h1);
		$display("test buffer done");
	endtask
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs;
		t_table;
		t_refuse;
		t_live;
		t_ext;
		t_buf;
		final_report;
	end
	initial begin
		repeat (20000) @(posedge pclk);
		err_total++;
		$display("watchdog expired");
		final_report;
	end
endmodule
